// File: logic/uinec_top.sv
// IN endpoint control low byte: stall, flush, underrun, packet ready, toggle clear
// Summary of operation
// - Writing one to clear-toggle resets the IN data toggle to zero.
// - Clear-toggle holds nothing and always reads back zero.
// - Every STALL handshake sent sets the stall-sent flag.
// - Sending a STALL also flushes the endpoint FIFO.
// - Writing one to flush pulses the endpoint FIFO flush for one cycle; packet ready is left as it is.
// - With send-stall set and isochronous mode off, every IN gets STALL, each raising an interrupt.
// - On IN with packet ready, send data, clear ready, raise interrupt.
// - Isochronous IN without packet sends zero-length data and sets underrun.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "uinec_params.svh"
module uinec_top
  import uinec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Token handler
  input  wire logic        in_token_i,
  input  wire logic        host_ack_i,
  output logic             tx_data_o,
  output logic             tx_zlp_o,
  output logic             tx_stall_o,
  output logic             tx_nak_o,
  output logic             data_toggle_o,
  // Endpoint FIFO
  input  wire logic        fifo_not_empty_i,
  output logic             fifo_flush_o,
  // Interrupt
  output logic             irq_o
);

  // ****************************************
  // Bus front end
  // ****************************************
  uinec_req_t  req;
  logic [31:0] rdata;

  uinec_wb_slave u_wb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .rdata_i   (rdata),
    .req_o     (req)
  );

  localparam logic [7:0] ADR_CTRL = 8'(`UINEC_IDX_CTRL_LOW << 2);

  uinec_core_t q;
  uinec_core_t next_q;

  logic       wr;
  logic [7:0] wd;
  logic       wr_ctrl;
  logic       stall_cond;
  logic [3:0] ev;

  // Only lane 0 carries data; the upper lanes alone do not write
  assign wr         = req.acc & req.we & req.sel[0];
  assign wd         = req.wdat[7:0];
  assign wr_ctrl    = wr && (req.adr == ADR_CTRL);
  // Stall request is ignored in isochronous mode
  assign stall_cond = q.send_stall & ~q.iso;

  // ****************************************
  // Read back
  // ****************************************
  always_comb begin
    rdata = '0;
    unique case (req.adr)
      ADR_CTRL: begin
        rdata[`UINEC_B_PKT_READY]  = q.pkt_ready;
        rdata[`UINEC_B_FIFO_NE]    = fifo_not_empty_i;
        rdata[`UINEC_B_UNDERRUN]   = q.underrun;
        rdata[`UINEC_B_SEND_STALL] = q.send_stall;
        rdata[`UINEC_B_STALL_SENT] = q.stall_sent;
        rdata[`UINEC_B_CLR_TOGGLE] = 1'b0;
      end
      `UINEC_ADR_CONFIG:   rdata[`UINEC_B_ISO] = q.iso;
      `UINEC_ADR_IRQ_STAT: rdata[3:0] = q.irq_stat;
      `UINEC_ADR_IRQ_EN:   rdata[3:0] = q.irq_en;
      default:             rdata = '0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_q       = q;
    next_q.resp  = '0;
    next_q.flush = 1'b0;
    ev           = '0;

    // Toggle follows the host ACK after a data packet
    unique case (q.st)
      UINEC_IDLE: begin
        next_q.st = UINEC_IDLE;
      end
      UINEC_WAIT_ACK: begin
        if (host_ack_i) begin
          next_q.toggle = ~q.toggle;
          next_q.st     = UINEC_IDLE;
        end else if (in_token_i) begin
          next_q.st = UINEC_IDLE;
        end
      end
    endcase

    // Token answer priority: stall, data, zero length, NAK
    if (in_token_i) begin
      if (stall_cond) begin
        next_q.resp.stall = 1'b1;
        next_q.flush      = 1'b1;
        ev[`UINEC_IRQ_STALL] = 1'b1;
      end else if (q.pkt_ready) begin
        next_q.resp.data = 1'b1;
        next_q.pkt_ready = 1'b0;
        ev[`UINEC_IRQ_SENT] = 1'b1;
        if (!q.iso) begin
          next_q.st = UINEC_WAIT_ACK;
        end
      end else if (q.iso) begin
        next_q.resp.zlp = 1'b1;
        ev[`UINEC_IRQ_UNDERRUN] = 1'b1;
      end else begin
        next_q.resp.nak = 1'b1;
        ev[`UINEC_IRQ_UNDERRUN] = 1'b1;
      end
    end

    // Software writes
    if (wr_ctrl) begin
      next_q.send_stall = wd[`UINEC_B_SEND_STALL];
      if (wd[`UINEC_B_PKT_READY]) begin
        next_q.pkt_ready = 1'b1;
      end
      // Zero clears the sticky flags; one leaves them
      if (!wd[`UINEC_B_STALL_SENT]) begin
        next_q.stall_sent = 1'b0;
      end
      if (!wd[`UINEC_B_UNDERRUN]) begin
        next_q.underrun = 1'b0;
      end
      if (wd[`UINEC_B_CLR_TOGGLE]) begin
        next_q.toggle = 1'b0;
      end
      if (wd[`UINEC_B_FLUSH]) begin
        next_q.flush = 1'b1;
        ev[`UINEC_IRQ_FLUSH] = fifo_not_empty_i;
      end
    end
    if (wr && req.adr == `UINEC_ADR_CONFIG) begin
      next_q.iso = wd[`UINEC_B_ISO];
    end
    if (wr && req.adr == `UINEC_ADR_IRQ_EN) begin
      next_q.irq_en = wd[3:0];
    end
    if (wr && req.adr == `UINEC_ADR_IRQ_CLR) begin
      next_q.irq_stat = q.irq_stat & ~wd[3:0];
    end

    // Hardware sets come last so they beat a clear in the same cycle
    if (next_q.resp.stall) begin
      next_q.stall_sent = 1'b1;
    end
    if (next_q.resp.zlp || next_q.resp.nak) begin
      next_q.underrun = 1'b1;
    end
    next_q.irq_stat = next_q.irq_stat | ev;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_en);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q        <= '0;
      q.irq_en <= `UINEC_IRQ_EN_RST;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_data_o     = q.resp.data;
  assign tx_zlp_o      = q.resp.zlp;
  assign tx_stall_o    = q.resp.stall;
  assign tx_nak_o      = q.resp.nak;
  assign data_toggle_o = q.toggle;
  assign fifo_flush_o  = q.flush;
  assign irq_o         = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_clr_toggle: assert property (
    wr_ctrl && wd[`UINEC_B_CLR_TOGGLE] |=> !data_toggle_o
  ) else $error("Toggle not cleared by command");

  chk_clr_readback: assert property (
    wb_ack_o && wb_adr_i == ADR_CTRL && !wb_we_i |-> !wb_dat_o[`UINEC_B_CLR_TOGGLE]
  ) else $error("Clear toggle bit read as one");

  chk_stall_flag: assert property (
    in_token_i && stall_cond |=> tx_stall_o && q.stall_sent
  ) else $error("Stall sent without flag");

  chk_stall_flush: assert property (
    tx_stall_o |-> fifo_flush_o
  ) else $error("Stall without FIFO flush");

  // A stall token right after the write may flush again; only that may extend the pulse
  chk_flush_cmd: assert property (
    wr_ctrl && wd[`UINEC_B_FLUSH] |=> fifo_flush_o ##1 (!fifo_flush_o || tx_stall_o)
  ) else $error("Flush command not issued");

  chk_stall_irq: assert property (
    in_token_i && stall_cond && q.irq_en[`UINEC_IRQ_STALL] |=> irq_o
  ) else $error("Stall did not raise interrupt");

  chk_flag_sticky: assert property (
    q.stall_sent && !wr_ctrl |=> q.stall_sent
  ) else $error("Stall flag cleared by hardware");

  chk_pkt_sent: assert property (
    in_token_i && !stall_cond && q.pkt_ready && !wr_ctrl
      |=> tx_data_o && !q.pkt_ready && q.irq_stat[`UINEC_IRQ_SENT]
  ) else $error("Packet ready token not answered with data");

  chk_iso_under: assert property (
    in_token_i && q.iso && !q.pkt_ready |=> tx_zlp_o && q.underrun
  ) else $error("Iso underrun not flagged");

  chk_nak_under: assert property (
    in_token_i && !q.iso && !q.send_stall && !q.pkt_ready |=> tx_nak_o && q.underrun
  ) else $error("NAK without underrun flag");

  chk_one_answer: assert property (
    in_token_i |=> $onehot({tx_stall_o, tx_data_o, tx_zlp_o, tx_nak_o})
  ) else $error("Token not answered by exactly one handshake");

  chk_no_token_quiet: assert property (
    !in_token_i |=> !tx_stall_o && !tx_data_o && !tx_zlp_o && !tx_nak_o
  ) else $error("Handshake sent without a token");

  chk_iso_no_stall: assert property (
    in_token_i && q.iso |=> !tx_stall_o
  ) else $error("Stall sent in isochronous mode");

  chk_under_sticky: assert property (
    q.underrun && !wr_ctrl |=> q.underrun
  ) else $error("Underrun flag cleared by hardware");

  chk_flush_irq: assert property (
    wr_ctrl && wd[`UINEC_B_FLUSH] && fifo_not_empty_i |=> q.irq_stat[`UINEC_IRQ_FLUSH]
  ) else $error("Flush of non-empty FIFO raised no status");

  chk_ack_toggle: assert property (
    q.st == UINEC_WAIT_ACK && host_ack_i && !(wr_ctrl && wd[`UINEC_B_CLR_TOGGLE])
      |=> data_toggle_o == !$past(data_toggle_o)
  ) else $error("Host ACK did not flip the toggle");

  cov_data_ack: cover property (
    tx_data_o ##[1:20] host_ack_i
  );

  cov_stall: cover property (
    tx_stall_o ##1 irq_o
  );

  cov_iso_zlp: cover property (
    tx_zlp_o
  );

  cov_flag_clear: cover property (
    q.underrun ##1 !q.underrun
  );

  cov_flush_cmd: cover property (
    fifo_flush_o && !tx_stall_o
  );

endmodule : uinec_top

// File: inc/uinec_params.svh
// Offsets, field positions, reset values and counts of the IN endpoint control block
`ifndef UINEC_PARAMS_SVH
`define UINEC_PARAMS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define UINEC_IDX_CTRL_LOW   8'h11
`define UINEC_ADR_CONFIG     8'h48
`define UINEC_ADR_IRQ_STAT   8'h4c
`define UINEC_ADR_IRQ_EN     8'h50
`define UINEC_ADR_IRQ_CLR    8'h54

// ****************************************
// Control low byte fields and the ISO bit of the config register
// ****************************************
`define UINEC_B_PKT_READY    0
`define UINEC_B_FIFO_NE      1
`define UINEC_B_UNDERRUN     2
`define UINEC_B_FLUSH        3
`define UINEC_B_SEND_STALL   4
`define UINEC_B_STALL_SENT   5
`define UINEC_B_CLR_TOGGLE   6
`define UINEC_B_ISO          0

// ****************************************
// Interrupt status fields
// ****************************************
`define UINEC_NUM_IRQ        4
`define UINEC_IRQ_SENT       0
`define UINEC_IRQ_STALL      1
`define UINEC_IRQ_FLUSH      2
`define UINEC_IRQ_UNDERRUN   3

// ****************************************
// Reset values
// ****************************************
`define UINEC_CTRL_RST       8'h00
`define UINEC_IRQ_EN_RST     4'h0

`endif

// File: inc/uinec_pkg.sv
// Types shared by the IN endpoint control block
package uinec_pkg;

  // ****************************************
  // Token handling state
  // ****************************************
  typedef enum logic [0:0] {
    UINEC_IDLE     = 1'b0,
    UINEC_WAIT_ACK = 1'b1
  } uinec_state_t;

  // ****************************************
  // Bus request as seen by the core
  // ****************************************
  typedef struct packed {
    logic        acc;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
  } uinec_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } uinec_wbs_t;

  // ****************************************
  // Handshake chosen for an IN token
  // ****************************************
  typedef struct packed {
    logic stall;
    logic data;
    logic zlp;
    logic nak;
  } uinec_resp_t;

  typedef struct packed {
    uinec_state_t st;
    logic         pkt_ready;
    logic         send_stall;
    logic         stall_sent;
    logic         underrun;
    logic         toggle;
    logic         iso;
    logic [3:0]   irq_stat;
    logic [3:0]   irq_en;
    uinec_resp_t  resp;
    logic         flush;
    logic         irq;
  } uinec_core_t;

endpackage : uinec_pkg

// File: logic/uinec_wb_slave.sv
// Classic Wishbone slave front end with one wait state
`timescale 1ns/10ps
module uinec_wb_slave
  import uinec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core side
  input  wire logic [31:0] rdata_i,
  output uinec_req_t       req_o
);

  uinec_wbs_t q;
  uinec_wbs_t next_q;

  // Commit on the edge where the master sees ack
  always_comb begin
    req_o.acc  = wb_cyc_i & wb_stb_i & q.ack;
    req_o.we   = wb_we_i;
    req_o.adr  = wb_adr_i;
    req_o.sel  = wb_sel_i;
    req_o.wdat = wb_dat_i;
  end

  always_comb begin
    next_q     = q;
    next_q.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      next_q.dat = rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;

endmodule : uinec_wb_slave

// File: tb/uinec_host_model.sv
// Behavioural USB host issuing IN tokens and handshakes
`timescale 1ns/10ps
module uinec_host_model
  import uinec_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Answer from the endpoint
  input  wire logic tx_data_i,
  input  wire logic tx_zlp_i,
  input  wire logic tx_stall_i,
  input  wire logic tx_nak_i,
  // Token side
  output logic      in_token_o,
  output logic      host_ack_o
);
  initial begin
    in_token_o = 1'b0;
    host_ack_o = 1'b0;
  end

  // Gap delays the ack to mimic a slow host
  task automatic in_xfer(input logic do_ack, input int gap, output uinec_resp_t resp);
    in_token_o <= 1'b1;
    @(posedge clk_sys_i);
    in_token_o <= 1'b0;
    @(posedge clk_sys_i);
    resp = '{stall: tx_stall_i, data: tx_data_i, zlp: tx_zlp_i, nak: tx_nak_i};
    if (resp.data && do_ack) begin
      repeat (gap) @(posedge clk_sys_i);
      host_ack_o <= 1'b1;
      @(posedge clk_sys_i);
      host_ack_o <= 1'b0;
    end
    @(posedge clk_sys_i);
  endtask : in_xfer
endmodule : uinec_host_model

// File: tb/tb.sv
// Self-checking bench for the IN endpoint control block
`timescale 1ns/10ps
`include "uinec_params.svh"
module tb
  import uinec_pkg::*;
;
  localparam logic [7:0] CTRL = `UINEC_IDX_CTRL_LOW << 2;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  sel       = 4'hf;
  logic        fne       = 1'b0;
  logic [31:0] rdat;
  logic        ack, tok, hack, txd, txz, txs, txn, tgl, flush, irq;
  uinec_resp_t r;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_flush = 0;
  int          n_cyc = 0;
  int          n0;

  always #25 clk_sys_i = ~clk_sys_i;

  uinec_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .in_token_i(tok), .host_ack_i(hack), .tx_data_o(txd), .tx_zlp_o(txz),
    .tx_stall_o(txs), .tx_nak_o(txn), .data_toggle_o(tgl), .fifo_not_empty_i(fne),
    .fifo_flush_o(flush), .irq_o(irq));

  uinec_host_model host (.clk_sys_i(clk_sys_i), .tx_data_i(txd), .tx_zlp_i(txz),
    .tx_stall_i(txs), .tx_nak_i(txn), .in_token_o(tok), .host_ack_o(hack));

  // Watchdog also counts flush pulses
  always @(posedge clk_sys_i) begin
    n_cyc++;
    if (flush === 1'b1)
      n_flush++;
    if (n_cyc == 4000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] rd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, q, exp);
  endtask : rdc

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rdc("ctrl", CTRL, `UINEC_CTRL_RST);
    rdc("irq_en", `UINEC_ADR_IRQ_EN, 8'h00);
    wr(8'h60, 8'hff);
    rdc("unmapped", 8'h60, 8'h00);
    // Writes without byte lane 0 must be dropped
    sel <= 4'he;
    wr(CTRL, 8'h01);
    sel <= 4'hf;
    rdc("no lane 0", CTRL, 8'h00);
    $display("done regs");
  endtask : t_regs

  task automatic t_data;
    wr(`UINEC_ADR_IRQ_EN, 8'h0f);
    wr(CTRL, 8'h01);
    host.in_xfer(1'b1, 3, r);
    chk("resp", {4'h0, r}, 8'h04);
    rdc("ctrl", CTRL, 8'h00);
    rdc("irq_stat", `UINEC_ADR_IRQ_STAT, 8'h01);
    chk("irq", {7'h0, irq}, 8'h01);
    chk("toggle", {7'h0, tgl}, 8'h01);
    wr(CTRL, 8'h40);
    chk("toggle", {7'h0, tgl}, 8'h00);
    rdc("ctrl", CTRL, 8'h00);
    wr(`UINEC_ADR_IRQ_CLR, 8'h0f);
    @(posedge clk_sys_i);
    chk("irq", {7'h0, irq}, 8'h00);
    $display("done data");
  endtask : t_data

  task automatic t_nak;
    host.in_xfer(1'b0, 0, r);
    chk("resp", {4'h0, r}, 8'h01);
    rdc("ctrl", CTRL, 8'h04);
    wr(CTRL, 8'h04);
    rdc("ctrl", CTRL, 8'h04);
    wr(CTRL, 8'h00);
    rdc("ctrl", CTRL, 8'h00);
    $display("done nak");
  endtask : t_nak

  task automatic t_stall;
    fne <= 1'b1;
    wr(`UINEC_ADR_IRQ_CLR, 8'h0f);
    wr(CTRL, 8'h10);
    n0 = n_flush;
    host.in_xfer(1'b1, 0, r);
    chk("resp", {4'h0, r}, 8'h08);
    chk("flushes", 8'(n_flush), 8'(n0 + 1));
    rdc("ctrl", CTRL, 8'h32);
    host.in_xfer(1'b1, 0, r);
    chk("resp", {4'h0, r}, 8'h08);
    rdc("irq_stat", `UINEC_ADR_IRQ_STAT, 8'h02);
    rdc("ctrl", CTRL, 8'h32);
    wr(CTRL, 8'h10);
    rdc("ctrl", CTRL, 8'h12);
    wr(CTRL, 8'h00);
    fne <= 1'b0;
    $display("done stall");
  endtask : t_stall

  task automatic t_iso;
    wr(`UINEC_ADR_CONFIG, 8'h01);
    wr(CTRL, 8'h10);
    host.in_xfer(1'b1, 0, r);
    chk("resp", {4'h0, r}, 8'h02);
    rdc("ctrl", CTRL, 8'h14);
    wr(CTRL, 8'h00);
    wr(`UINEC_ADR_CONFIG, 8'h00);
    $display("done iso");
  endtask : t_iso

  task automatic t_flush;
    fne <= 1'b1;
    wr(`UINEC_ADR_IRQ_CLR, 8'h0f);
    n0 = n_flush;
    wr(CTRL, 8'h08);
    rdc("ctrl", CTRL, 8'h02);
    chk("flushes", 8'(n_flush), 8'(n0 + 1));
    rdc("irq_stat", `UINEC_ADR_IRQ_STAT, 8'h04);
    wr(`UINEC_ADR_IRQ_EN, 8'h00);
    @(posedge clk_sys_i);
    chk("irq", {7'h0, irq}, 8'h00);
    fne <= 1'b0;
    $display("done flush");
  endtask : t_flush

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_data();
    t_nak();
    t_stall();
    t_iso();
    t_flush();
    finish_test();
  end
endmodule : tb
